// file: common/clkdiv_pkg.sv
// constants and types shared by the output clock divider files
package clkdiv_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FIELD_W = 4;
  localparam int unsigned RUN_W = 6;
  // register map: one byte per output, even offsets from first to last
  localparam logic [ADDR_W-1:0] FIRST_DIV_REG = 8'h4a;
  localparam logic [ADDR_W-1:0] LAST_DIV_REG = 8'h52;
  localparam logic [ADDR_W-1:0] DIV_REG_STRIDE = 8'h02;
  localparam logic [DATA_W-1:0] DIV_REG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
  // field positions inside a divider register
  localparam int unsigned LOWER_FIELD_MSB = 7;
  localparam int unsigned LOWER_FIELD_LSB = 4;
  localparam int unsigned UPPER_FIELD_MSB = 3;
  localparam int unsigned UPPER_FIELD_LSB = 0;
  localparam logic [FIELD_W-1:0] FIELD_ZERO = 4'h0;
  localparam logic [FIELD_W-1:0] FIELD_ONE = 4'h1;
  localparam logic [RUN_W-1:0] RUN_ONE = 6'h01;
  localparam logic [RUN_W-1:0] MIN_RATIO = 6'h02;
  localparam logic [RUN_W-1:0] MAX_RATIO = 6'h20;
  // divider sequencer states, gray coded along bypass -> high -> low
  typedef enum logic [1:0] {
    ST_BYPASS = 2'b00,
    ST_HIGH   = 2'b01,
    ST_LOW    = 2'b11
  } div_state_t;
endpackage : clkdiv_pkg

// file: common/div_cfg_if.sv
// configuration carried from the divider register to the divider core
interface div_cfg_if;
  import clkdiv_pkg::*;
  logic [FIELD_W-1:0] upper_time_field;
  logic [FIELD_W-1:0] lower_time_field;
  logic               bypass;
  modport regs (output upper_time_field, output lower_time_field, output bypass);
  modport core (input upper_time_field, input lower_time_field, input bypass);
endinterface : div_cfg_if

// file: rtl/div_cfg_reg.sv
// divider count register for one output, written at its own address
module div_cfg_reg
  import clkdiv_pkg::*;
#(
  parameter logic [clkdiv_pkg::ADDR_W-1:0] REG_ADDR = clkdiv_pkg::FIRST_DIV_REG
)
(
  input  wire logic                          clock,
  input  wire logic                          rst_n,
  input  wire logic [clkdiv_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [clkdiv_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          bypass_in,
  div_cfg_if.regs                            cfg
);
  typedef struct packed {
    logic [DATA_W-1:0] counts;
    logic              bypass;
  } cfg_state_t;

  cfg_state_t s_q;
  cfg_state_t s_d;

  // write decode: only this output's address loads the counts
  always_comb
  begin
    s_d = s_q;
    s_d.bypass = bypass_in;
    if (reg_wr && reg_addr == REG_ADDR)
    begin
      s_d.counts = reg_wdata;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      s_q <= '{counts: DIV_REG_RESET, bypass: 1'b0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign cfg.lower_time_field = s_q.counts[LOWER_FIELD_MSB:LOWER_FIELD_LSB];
  assign cfg.upper_time_field = s_q.counts[UPPER_FIELD_MSB:UPPER_FIELD_LSB];
  assign cfg.bypass = s_q.bypass;

  field_split_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    reg_wr && reg_addr == REG_ADDR
      |=> cfg.lower_time_field == $past(reg_wdata[LOWER_FIELD_MSB:LOWER_FIELD_LSB])
      && cfg.upper_time_field == $past(reg_wdata[UPPER_FIELD_MSB:UPPER_FIELD_LSB]))
    else $error("divider fields do not match the written byte");
endmodule // div_cfg_reg

// file: rtl/output_clock_divider_duty.sv
// one output divider: programmable high and low phase counts
module output_clock_divider_duty
  import clkdiv_pkg::*;
#(
  parameter logic [clkdiv_pkg::ADDR_W-1:0] REG_ADDR = clkdiv_pkg::FIRST_DIV_REG
)
(
  input  wire logic                          clock,
  input  wire logic                          rst_n,
  input  wire logic [clkdiv_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [clkdiv_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  input  wire logic                          bypass,
  output logic      [clkdiv_pkg::DATA_W-1:0] reg_rdata_q,
  output logic                               div_out_q,
  output logic                               period_tick_q
);
  typedef struct packed {
    div_state_t         st;
    logic [FIELD_W-1:0] cnt;
    logic [FIELD_W-1:0] upper_act;
    logic [FIELD_W-1:0] lower_act;
    logic               out;
    logic               tick;
    logic [DATA_W-1:0]  rdata;
    logic [RUN_W-1:0]   run;
    logic [RUN_W-1:0]   per;
    logic               out_prev;
  } core_state_t;

  core_state_t s_q;
  core_state_t s_d;

  div_cfg_if cfg ();

  // register slot for this output
  div_cfg_reg #(
    .REG_ADDR (REG_ADDR)
  ) u_cfg (
    .clock     (clock),
    .rst_n     (rst_n),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .bypass_in (bypass),
    .cfg       (cfg.regs)
  );

  // sequencer: counts are taken only at a period boundary so a write
  // mid-period never produces a runt pulse; cost is one period of latency
  always_comb
  begin
    s_d = s_q;
    s_d.tick = 1'b0;
    s_d.rdata = READ_ZERO;
    // register read returns the stored fields, zero elsewhere
    if (reg_rd && reg_addr == REG_ADDR)
    begin
      s_d.rdata = {cfg.lower_time_field, cfg.upper_time_field};
    end
    case (s_q.st)
      ST_BYPASS:
      begin
        s_d.out = 1'b1;
        s_d.tick = 1'b1;
        s_d.cnt = FIELD_ZERO;
        s_d.upper_act = cfg.upper_time_field;
        s_d.lower_act = cfg.lower_time_field;
        if (!cfg.bypass)
        begin
          s_d.st = ST_HIGH;
        end
      end
      ST_HIGH:
      begin
        if (s_q.cnt == s_q.upper_act)
        begin
          s_d.st = ST_LOW;
          s_d.cnt = FIELD_ZERO;
          s_d.out = 1'b0;
        end
        else
        begin
          s_d.cnt = s_q.cnt + FIELD_ONE;
        end
      end
      ST_LOW:
      begin
        if (s_q.cnt == s_q.lower_act)
        begin
          s_d.cnt = FIELD_ZERO;
          s_d.out = 1'b1;
          s_d.tick = 1'b1;
          s_d.upper_act = cfg.upper_time_field;
          s_d.lower_act = cfg.lower_time_field;
          s_d.st = cfg.bypass ? ST_BYPASS : ST_HIGH;
        end
        else
        begin
          s_d.cnt = s_q.cnt + FIELD_ONE;
        end
      end
      default:
      begin
        s_d.st = ST_HIGH;
        s_d.cnt = FIELD_ZERO;
        s_d.out = 1'b1;
      end
    endcase
    // checking helpers: length of the current level and of the period;
    // a period start also restarts the level count, so time spent in
    // bypass is not counted into the first high phase after leaving it
    s_d.run = (s_d.out != s_q.out || s_d.tick) ? RUN_ONE : s_q.run + RUN_ONE;
    s_d.per = s_d.tick ? RUN_ONE : s_q.per + RUN_ONE;
    s_d.out_prev = s_q.out;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      s_q <= '{st: ST_HIGH, cnt: FIELD_ZERO, upper_act: FIELD_ZERO,
               lower_act: FIELD_ZERO, out: 1'b1, tick: 1'b0, rdata: READ_ZERO,
               run: RUN_ONE, per: RUN_ONE, out_prev: 1'b1};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign div_out_q = s_q.out;
  assign period_tick_q = s_q.tick;
  assign reg_rdata_q = s_q.rdata;

  // checking helpers: active ratio and the edges of the output level
  logic [RUN_W-1:0] ratio_w;
  logic             fall_w;
  logic             rise_w;

  assign ratio_w = RUN_W'(s_q.upper_act) + RUN_W'(s_q.lower_act) + MIN_RATIO;
  assign fall_w = !s_q.out && s_q.out_prev;
  assign rise_w = s_q.out && !s_q.out_prev;

  high_run_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    fall_w && s_q.st == ST_LOW |-> $past(s_q.run) == RUN_W'(s_q.upper_act) + RUN_ONE)
    else $error("high phase length differs from upper field plus one");

  low_run_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_q.st == ST_LOW && s_q.cnt == s_q.lower_act && !cfg.bypass
      |=> s_q.out && $past(s_q.run) == RUN_W'($past(s_q.lower_act)) + RUN_ONE)
    else $error("low phase length differs from lower field plus one");

  period_len_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_q.st == ST_LOW && s_q.cnt == s_q.lower_act && s_q.per != RUN_ONE
      && $past(s_q.st) != ST_BYPASS |=> $past(s_q.per) == $past(ratio_w))
    else $error("period differs from the programmed ratio");

  split_kept_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    rise_w && $past(s_q.upper_act) != $past(s_q.lower_act)
      |-> $past(s_q.run) != RUN_W'($past(s_q.upper_act)) + RUN_ONE)
    else $error("unequal split produced equal phases");

  ratio_two_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_q.st == ST_HIGH && ratio_w == MIN_RATIO |=> !s_q.out ##1 s_q.out || cfg.bypass)
    else $error("ratio two output is not symmetric");

  ratio_four_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    fall_w && ratio_w == 6'h04 |-> $past(s_q.run) inside {6'h01, 6'h02, 6'h03})
    else $error("ratio four high time outside one to three cycles");

  ratio_range_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_q.st != ST_BYPASS |-> ratio_w >= MIN_RATIO && ratio_w <= MAX_RATIO)
    else $error("active ratio outside two to thirty-two");

  bypass_rate_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_q.st == ST_BYPASS && cfg.bypass |=> s_q.out && s_q.tick [*2])
    else $error("bypass does not pass the input rate");

  // read path returns stored byte one cycle later
  read_back_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    reg_rd && reg_addr == REG_ADDR && !reg_wr
      |=> reg_rdata_q == {cfg.lower_time_field, cfg.upper_time_field})
    else $error("register read does not return stored counts");

  tick_on_rise_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    rise_w |-> period_tick_q && div_out_q)
    else $error("output rise without a period start mark");
endmodule // output_clock_divider_duty

// file: bench/conv_model.sv
// converter-side model: measures high and low run lengths of the divided clock
module conv_model
(
  input  wire logic       clock,
  input  wire logic       div_in,
  output logic      [5:0] hi_len,
  output logic      [5:0] lo_len
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       prev_q;
  logic [5:0] run_hi;
  logic [5:0] run_lo;
  // a rising edge closes a period; the first one measured is junk, later ones exact
  always @(posedge clock)
  begin
    if (div_in && !prev_q)
    begin
      hi_len <= run_hi;
      lo_len <= run_lo;
      run_hi <= 6'h01;
      run_lo <= 6'h00;
    end
    else if (div_in)
      run_hi <= run_hi + 6'h01;
    else
      run_lo <= run_lo + 6'h01;
    prev_q <= div_in;
  end
endmodule // conv_model

// file: bench/test_output_clock_divider_duty.sv
// self-checking bench for one output divider
module test_output_clock_divider_duty;
  timeunit 1ns;
  timeprecision 1ns;
  import clkdiv_pkg::*;
  logic       clock, rst_n, reg_wr, reg_rd, bypass, div_out_q, period_tick_q;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q, rd_v, last_cfg;
  logic [5:0] hi_len, lo_len;
  int         n_errors, num_checks, cycles;

  output_clock_divider_duty #(.REG_ADDR(FIRST_DIV_REG)) dut (.clock(clock), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .bypass(bypass), .reg_rdata_q(reg_rdata_q), .div_out_q(div_out_q),
    .period_tick_q(period_tick_q));
  conv_model conv (.clock(clock), .div_in(div_out_q), .hi_len(hi_len), .lo_len(lo_len));

  // 10 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // hang guard: runs need well under this many cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      results();
    end
  end

  task automatic results();
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #10 reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clock);
    #10 reg_wr = 1'b0;
  endtask

  // read data lands at the edge that takes the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    #10 reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clock);
    #10 reg_rd = 1'b0;
    rd_v = reg_rdata_q;
  endtask

  task automatic ticks(input int n);
    int k;
    k = 0;
    while (k < n)
    begin
      @(posedge clock);
      #10;
      if (period_tick_q === 1'b1)
        k++;
    end
  endtask

  // a phase lasts its field value plus one input cycle
  function automatic logic [7:0] run_len(input logic [3:0] f);
    return 8'(f) + 8'h01;
  endfunction

  // new counts apply from a period boundary, so let two whole periods pass
  task automatic run(input logic [3:0] lo, input logic [3:0] hi);
    last_cfg = {lo, hi};
    wr(FIRST_DIV_REG, last_cfg);
    rd(FIRST_DIV_REG);
    chk(last_cfg, rd_v);
    ticks(3);
    @(posedge clock);
    #10;
    chk(run_len(hi), 8'(hi_len));
    chk(run_len(lo), 8'(lo_len));
  endtask

  // main sequence: reset, table corners, random splits, foreign address, bypass
  initial
  begin
    n_errors = 0;
    num_checks = 0;
    cycles = 0;
    {rst_n, reg_wr, reg_rd, bypass} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    void'($urandom(14));
    repeat (5) @(posedge clock);
    #10 rst_n = 1'b1;
    rd(FIRST_DIV_REG);
    chk(DIV_REG_RESET, rd_v);
    run(4'h0, 4'h0);
    run(4'h2, 4'h0);
    run(4'h1, 4'h1);
    run(4'h0, 4'h2);
    run(4'h3, 4'h3);
    run(4'h4, 4'h2);
    run(4'hf, 4'hf);
    run(4'h0, 4'hf);
    repeat (6) run(4'($urandom), 4'($urandom));
    wr(8'h4c, 8'h5a);
    rd(8'h4c);
    chk(READ_ZERO, rd_v);
    rd(FIRST_DIV_REG);
    chk(last_cfg, rd_v);
    bypass = 1'b1;
    ticks(3);
    repeat (8)
    begin
      @(posedge clock);
      #10 chk(8'h03, {6'h00, div_out_q, period_tick_q});
    end
    bypass = 1'b0;
    run(4'h2, 4'h1);
    results();
  end
endmodule // test_output_clock_divider_duty
